//--- inc/blit_defs.svh
// Constants for the vram block copy and fill engine
`ifndef BLIT_DEFS_SVH
`define BLIT_DEFS_SVH

`define CB_W 152
`define CB_LAST 5'h12
`define CB_SRC_ADR 5'h00
`define CB_SRC_STEP 5'h03
`define CB_DST_ADR 5'h05
`define CB_DST_STEP 5'h08
`define CB_WIDTH 5'h0A
`define CB_HEIGHT 5'h0C
`define CB_AND 5'h0D
`define CB_XOR 5'h0E
`define CB_COL 5'h0F
`define CB_ZOOM 5'h10
`define CB_PAT 5'h11
`define CB_CTRL 5'h12

`define ZOOM_SKIP_BIT 3
`define PAT_EN_BIT 7
`define CTRL_DST_VERT 7
`define CTRL_DST_HORIZ 6
`define CTRL_SRC_VERT 5
`define CTRL_SRC_HORIZ 4
`define CTRL_NEXT 3

`define MODE_COPY 3'h0
`define MODE_OVER 3'h1
`define MODE_ADD 3'h2
`define MODE_OR 3'h3
`define MODE_AND 3'h4
`define MODE_XOR 3'h5
`define MODE_NIB 3'h6

`define ADR_RST 19'h00000
`define BYTE_RST 8'h00

`endif

//--- inc/blit_pkg.sv
// Types of the vram block copy and fill engine
`include "blit_defs.svh"
package blit_pkg;

typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_BLOCK_INIT, S_PIX, S_SRC_RD, S_OUT, S_DST_RD,
    S_DST_WR, S_STEP, S_END
} state_t;

typedef struct packed {
    state_t st;
    logic [`CB_W-1:0] cmd;
    logic [4:0] fcnt;
    logic [18:0] fetch_adr, list_adr, src_base, src_work;
    logic [18:0] dst_base, dst_work;
    logic [7:0] srcv, wdata, coll;
    logic [8:0] x_cnt;
    logic [7:0] y_cnt;
    logic [2:0] zx, zy;
    logic [5:0] pat;
    logic irq_en, irq_flag;
} engine_state_t;

endpackage

//--- hdl/pixel_combine.sv
// Combine unit: mode logic, transparency and collision capture
`timescale 1ns/10ps
`include "blit_defs.svh"
module pixel_combine
    import blit_pkg::*;
(
    input wire logic [2:0] mode_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] dst_i,
    input wire logic [7:0] col_mask_i,
    input wire logic [7:0] coll_i,
    output logic write_o,
    output logic [7:0] wdata_o,
    output logic [7:0] coll_o
);
    logic nz;
    logic hit;

    always_comb
    begin
        nz = (src_i != 8'h00);
        hit = nz && ((dst_i & col_mask_i) != 8'h00);
        write_o = 1'b0;
        wdata_o = src_i;
        coll_o = coll_i;
        case (mode_i)
            `MODE_COPY: write_o = 1'b1;
            `MODE_OVER:
            begin
                write_o = nz;
                if (hit)
                    coll_o = dst_i;
            end
            `MODE_ADD, `MODE_OR, `MODE_XOR:
            begin
                write_o = nz;
                if (hit)
                    coll_o = dst_i;
                if (mode_i == `MODE_ADD)
                    wdata_o = 8'(dst_i + src_i);
                else if (mode_i == `MODE_OR)
                    wdata_o = dst_i | src_i;
                else
                    wdata_o = dst_i ^ src_i;
            end
            `MODE_AND:
            begin
                write_o = 1'b1;
                wdata_o = dst_i & src_i;
                if (hit)
                    coll_o = dst_i;
            end
            `MODE_NIB:
            begin
                write_o = nz;
                // nibble-wise transparency, low mask nibble for both
                if (src_i[3:0] != 4'h0)
                begin
                    if ((dst_i[3:0] & col_mask_i[3:0]) != 4'h0)
                        coll_o[3:0] = dst_i[3:0];
                end
                else
                    wdata_o[3:0] = dst_i[3:0];
                if (src_i[7:4] != 4'h0)
                begin
                    if ((dst_i[7:4] & col_mask_i[3:0]) != 4'h0)
                        coll_o[7:4] = dst_i[7:4];
                end
                else
                    wdata_o[7:4] = dst_i[7:4];
            end
            default: write_o = 1'b0; // reserved mode leaves memory alone
        endcase
    end
endmodule // pixel_combine

//--- hdl/vram_block_copy_fill_engine.sv
// Two-dimensional block copy and fill engine over video RAM
`timescale 1ns/10ps
`include "blit_defs.svh"
module vram_block_copy_fill_engine
    import blit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [2:0] list_adr_write_i,
    input wire logic [7:0] list_adr_byte_i,
    input wire logic start_write_i,
    input wire logic start_bit_i,
    input wire logic irq_write_i,
    input wire logic done_irq_enable_i,
    output logic [18:0] list_pointer_o,
    output logic busy_o,
    output logic block_fetch_flag_o,
    output logic done_irq_o,
    output logic [7:0] collision_code_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [18:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i
);
    engine_state_t s;
    engine_state_t next_s;

    function automatic logic [7:0] cb_byte(input logic [`CB_W-1:0] c,
                                           input logic [4:0] i);
        cb_byte = c[{i, 3'h0} +: 8];
    endfunction

    function automatic logic [18:0] adr19(input logic [`CB_W-1:0] c,
                                          input logic [4:0] i);
        logic [7:0] hi;
        hi = cb_byte(c, 5'(i + 5'h02));
        adr19 = {hi[2:0], cb_byte(c, 5'(i + 5'h01)), cb_byte(c, i)};
    endfunction

    function automatic logic [11:0] step12(input logic [`CB_W-1:0] c,
                                           input logic [4:0] i);
        logic [7:0] hi;
        hi = cb_byte(c, 5'(i + 5'h01));
        step12 = {hi[3:0], cb_byte(c, i)};
    endfunction

    // wraps modulo the 19-bit space
    function automatic logic [18:0] walk(input logic [18:0] a,
                                         input logic [11:0] d,
                                         input logic down);
        walk = down ? 19'(a - {7'h00, d}) : 19'(a + {7'h00, d});
    endfunction

    logic [7:0] and_m, xor_m, col_m, zoom, patb, ctrl, height, width_hi;
    logic [2:0] mode, zoom_x, zoom_y;
    logic [11:0] src_step, dst_step, dst_inc;
    logic [8:0] width;
    logic [5:0] pat_w;
    logic const_src, pat_en, need_rd;
    logic [7:0] cmb_dst, cmb_wdata, cmb_coll;
    logic cmb_we;
    logic [18:0] dst_line, src_line;

    assign and_m = cb_byte(s.cmd, `CB_AND);
    assign xor_m = cb_byte(s.cmd, `CB_XOR);
    assign col_m = cb_byte(s.cmd, `CB_COL);
    assign zoom = cb_byte(s.cmd, `CB_ZOOM);
    assign patb = cb_byte(s.cmd, `CB_PAT);
    assign ctrl = cb_byte(s.cmd, `CB_CTRL);
    assign height = cb_byte(s.cmd, `CB_HEIGHT);
    assign mode = ctrl[2:0];
    assign zoom_x = zoom[2:0];
    assign zoom_y = zoom[6:4];
    assign src_step = step12(s.cmd, `CB_SRC_STEP);
    assign dst_step = step12(s.cmd, `CB_DST_STEP);
    assign width_hi = cb_byte(s.cmd, 5'(`CB_WIDTH + 5'h01));
    assign width = {width_hi[0], cb_byte(s.cmd, `CB_WIDTH)};
    assign pat_en = patb[`PAT_EN_BIT];
    assign pat_w = patb[5:0];
    assign const_src = ((~and_m ^ xor_m) == 8'hFF);
    assign dst_inc = zoom[`ZOOM_SKIP_BIT] ? 12'h002 : 12'h001;
    assign dst_line = walk(s.dst_base, dst_step, ctrl[`CTRL_DST_VERT]);
    assign src_line = walk(s.src_base, src_step, ctrl[`CTRL_SRC_VERT]);

    // destination read only where the mode needs the old value
    always_comb
    begin
        case (mode)
            `MODE_COPY: need_rd = 1'b0;
            `MODE_OVER: need_rd = (s.srcv != 8'h00)
                                  && (col_m != 8'h00);
            `MODE_AND: need_rd = 1'b1;
            `MODE_ADD, `MODE_OR, `MODE_XOR, `MODE_NIB:
                need_rd = (s.srcv != 8'h00);
            default: need_rd = 1'b0;
        endcase
    end

    assign cmb_dst = (s.st == S_DST_RD) ? mem_rdata_i : `BYTE_RST;

    pixel_combine u_combine (
        .mode_i(mode),
        .src_i(s.srcv),
        .dst_i(cmb_dst),
        .col_mask_i(col_m),
        .coll_i(s.coll),
        .write_o(cmb_we),
        .wdata_o(cmb_wdata),
        .coll_o(cmb_coll)
    );

    always_comb
    begin
        next_s = s;
        if (list_adr_write_i[0])
            next_s.list_adr[7:0] = list_adr_byte_i;
        if (list_adr_write_i[1])
            next_s.list_adr[15:8] = list_adr_byte_i;
        if (list_adr_write_i[2])
            next_s.list_adr[18:16] = list_adr_byte_i[2:0];
        if (irq_write_i)
        begin
            next_s.irq_en = done_irq_enable_i;
            next_s.irq_flag = 1'b0;
        end
        case (s.st)
            S_IDLE:
                if (start_write_i && start_bit_i)
                begin
                    next_s.st = S_FETCH;
                    next_s.fetch_adr = s.list_adr;
                    next_s.fcnt = 5'h00;
                end
            S_FETCH:
                if (mem_ack_i)
                begin
                    // first byte ends at the bottom of the record
                    next_s.cmd = {mem_rdata_i, s.cmd[`CB_W-1:8]};
                    next_s.fetch_adr = 19'(s.fetch_adr + 19'h00001);
                    next_s.fcnt = 5'(s.fcnt + 5'h01);
                    if (s.fcnt == `CB_LAST)
                        next_s.st = S_BLOCK_INIT;
                end
            S_BLOCK_INIT:
            begin
                next_s.src_base = adr19(s.cmd, `CB_SRC_ADR);
                next_s.src_work = adr19(s.cmd, `CB_SRC_ADR);
                next_s.dst_base = adr19(s.cmd, `CB_DST_ADR);
                next_s.dst_work = adr19(s.cmd, `CB_DST_ADR);
                next_s.x_cnt = 9'h000;
                next_s.y_cnt = 8'h00;
                next_s.zx = 3'h0;
                next_s.zy = 3'h0;
                next_s.pat = 6'h00;
                next_s.st = S_PIX;
            end
            S_PIX:
                if (const_src)
                begin
                    next_s.srcv = xor_m;
                    next_s.st = S_OUT;
                end
                else
                    next_s.st = S_SRC_RD;
            S_SRC_RD:
                if (mem_ack_i)
                begin
                    next_s.srcv = (mem_rdata_i & and_m) ^ xor_m;
                    next_s.st = S_OUT;
                end
            S_OUT:
                if (need_rd)
                    next_s.st = S_DST_RD;
                else
                begin
                    next_s.wdata = cmb_wdata;
                    next_s.st = cmb_we ? S_DST_WR : S_STEP;
                end
            S_DST_RD:
                if (mem_ack_i)
                begin
                    next_s.wdata = cmb_wdata;
                    next_s.coll = cmb_coll;
                    next_s.st = cmb_we ? S_DST_WR : S_STEP;
                end
            S_DST_WR:
                if (mem_ack_i)
                    next_s.st = S_STEP;
            S_STEP:
            begin
                next_s.st = S_PIX;
                next_s.dst_work = walk(s.dst_work, dst_inc,
                                       ctrl[`CTRL_DST_HORIZ]);
                if (s.zx != zoom_x)
                begin
                    next_s.zx = 3'(s.zx + 3'h1);
                    next_s.st = S_OUT;
                end
                else if (s.x_cnt != width)
                begin
                    next_s.zx = 3'h0;
                    next_s.x_cnt = 9'(s.x_cnt + 9'h001);
                    if (pat_en && (s.pat == pat_w))
                    begin
                        next_s.pat = 6'h00;
                        next_s.src_work = s.src_base;
                    end
                    else
                    begin
                        next_s.pat = 6'(s.pat + 6'h01);
                        next_s.src_work = walk(s.src_work, 12'h001,
                                               ctrl[`CTRL_SRC_HORIZ]);
                    end
                end
                else
                begin
                    // width exhausted: pattern cut short here
                    next_s.zx = 3'h0;
                    next_s.x_cnt = 9'h000;
                    next_s.pat = 6'h00;
                    next_s.dst_base = dst_line;
                    next_s.dst_work = dst_line;
                    next_s.src_work = s.src_base;
                    if (s.zy != zoom_y)
                        next_s.zy = 3'(s.zy + 3'h1);
                    else if (s.y_cnt != height)
                    begin
                        next_s.zy = 3'h0;
                        next_s.y_cnt = 8'(s.y_cnt + 8'h01);
                        next_s.src_base = src_line;
                        next_s.src_work = src_line;
                    end
                    else
                        next_s.st = S_END;
                end
            end
            S_END:
                if (ctrl[`CTRL_NEXT])
                begin
                    next_s.st = S_FETCH;
                    next_s.fcnt = 5'h00;
                end
                else
                begin
                    next_s.st = S_IDLE;
                    if (next_s.irq_en)
                        next_s.irq_flag = 1'b1;
                end
            default: next_s.st = S_IDLE;
        endcase
        // abort overrides the next state from any state but S_IDLE
        if (start_write_i && !start_bit_i && (s.st != S_IDLE))
            next_s.st = S_IDLE;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s <= '0;
        else if (ce_i)
            s <= next_s;
    end

    assign busy_o = (s.st != S_IDLE) && (s.st != S_FETCH);
    assign block_fetch_flag_o = (s.st == S_FETCH);
    assign done_irq_o = s.irq_flag;
    assign collision_code_o = s.coll;
    assign list_pointer_o = s.list_adr;
    assign mem_req_o = (s.st == S_FETCH) || (s.st == S_SRC_RD)
                       || (s.st == S_DST_RD) || (s.st == S_DST_WR);
    assign mem_we_o = (s.st == S_DST_WR);
    assign mem_wdata_o = s.wdata;
    assign mem_addr_o = (s.st == S_FETCH) ? s.fetch_adr :
                        (s.st == S_SRC_RD) ? s.src_work : s.dst_work;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_fetch_len;
        (s.st == S_FETCH) && ce_i && mem_ack_i && (s.fcnt == `CB_LAST)
        && !start_write_i |=> (s.st == S_BLOCK_INIT);
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("block not started after last record byte");

    property p_work_load;
        (s.st == S_BLOCK_INIT) && ce_i |=>
            (s.src_work == s.src_base) && (s.dst_work == s.dst_base);
    endproperty
    a_work_load: assert property (p_work_load)
        else $error("working counters not loaded from bases");

    property p_const_src;
        (s.st == S_PIX) && ce_i && const_src && !start_write_i
        |=> (s.srcv == xor_m) && (s.st == S_OUT);
    endproperty
    a_const_src: assert property (p_const_src)
        else $error("constant source not taken from xor mask");

    property p_copy_no_read;
        (mode == `MODE_COPY) |-> (s.st != S_DST_RD);
    endproperty
    a_copy_no_read: assert property (p_copy_no_read)
        else $error("destination read in copy mode");

    property p_over_fast;
        (mode == `MODE_OVER) && (col_m == 8'h00) |-> (s.st != S_DST_RD);
    endproperty
    a_over_fast: assert property (p_over_fast)
        else $error("destination read with zero collision mask");

    property p_and_reads;
        (s.st == S_OUT) && ce_i && (mode == `MODE_AND) && !start_write_i
        |=> (s.st == S_DST_RD);
    endproperty
    a_and_reads: assert property (p_and_reads)
        else $error("and mode skipped destination read");

    property p_chain;
        (s.st == S_END) && ce_i && ctrl[`CTRL_NEXT] && !start_write_i
        |=> block_fetch_flag_o && !busy_o
            && (mem_addr_o == $past(s.fetch_adr));
    endproperty
    a_chain: assert property (p_chain)
        else $error("continuation did not refetch at list position");

    property p_done_irq;
        (s.st == S_END) && ce_i && !ctrl[`CTRL_NEXT] && s.irq_en
        && !irq_write_i |=> done_irq_o && !busy_o
        ##1 (done_irq_o || $past(irq_write_i));
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("done interrupt not raised on finish");

    property p_abort;
        start_write_i && !start_bit_i && ce_i
        |=> (s.st == S_IDLE) && !busy_o && !block_fetch_flag_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not stop engine");

    property p_list_kept;
        (s.st != S_IDLE) && (list_adr_write_i == 3'h0)
        |=> $stable(list_pointer_o);
    endproperty
    a_list_kept: assert property (p_list_kept)
        else $error("list address changed by engine");

    property p_horiz_step;
        (s.st == S_STEP) && ce_i && (s.zx != zoom_x) && !start_write_i
        |=> (s.dst_work == walk($past(s.dst_work), dst_inc,
                                 ctrl[`CTRL_DST_HORIZ]));
    endproperty
    a_horiz_step: assert property (p_horiz_step)
        else $error("destination step wrong within line");

    c_chain: cover property ((s.st == S_END) && ctrl[`CTRL_NEXT] ##1
                             block_fetch_flag_o);
    c_nib_write: cover property ((mode == `MODE_NIB) && mem_we_o);
    c_const_fill: cover property ((s.st == S_PIX) && const_src);
    c_abort: cover property (busy_o && start_write_i && !start_bit_i);
endmodule // vram_block_copy_fill_engine

//--- tb/vram_model.sv
// Video RAM partner model with prompt and slow acknowledges
`timescale 1ns/10ps
module vram_model (
    input wire logic clk_sys_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [18:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic ack_o,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:524287];
    logic ack = 1'b0;
    logic slow = 1'b0;
    logic [1:0] waited = 2'h0;
    logic [7:0] rd = 8'h00;
    assign ack_o = ack;
    assign rdata_o = rd;
    initial
    begin
        for (int i = 0; i < 524288; i++)
            mem[i] = 8'h00;
    end
    // data lines toggle when not answering, so stale data never passes
    always @(posedge clk_sys_i)
    begin
        if (ack || !req_i)
        begin
            ack <= 1'b0;
            rd <= ~rd;
        end
        else if (waited == {slow, 1'b0})
        begin
            ack <= 1'b1;
            waited <= 2'h0;
            slow <= ~slow;
            rd <= mem[addr_i];
            if (we_i)
                mem[addr_i] <= wdata_i;
        end
        else
        begin
            waited <= waited + 2'h1;
            rd <= ~rd;
        end
    end
endmodule // vram_model

//--- tb/tb.sv
// Self-checking bench of the block copy and fill engine
`timescale 1ns/10ps
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] la_wr = 3'h0;
    logic [7:0] la_byte = 8'h00;
    logic st_wr = 1'b0;
    logic st_bit = 1'b0;
    logic irq_wr = 1'b0;
    logic irq_en = 1'b0;
    logic ce = 1'b1;
    logic [18:0] list_ptr, addr;
    logic busy, fetch, irq, req, we, ack;
    logic [7:0] coll, wdata, rdata;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    int both_hi = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    vram_block_copy_fill_engine u_vram_block_copy_fill_engine (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .list_adr_write_i(la_wr), .list_adr_byte_i(la_byte),
        .start_write_i(st_wr), .start_bit_i(st_bit),
        .irq_write_i(irq_wr), .done_irq_enable_i(irq_en),
        .list_pointer_o(list_ptr), .busy_o(busy),
        .block_fetch_flag_o(fetch), .done_irq_o(irq),
        .collision_code_o(coll), .mem_req_o(req), .mem_we_o(we),
        .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_ack_i(ack),
        .mem_rdata_i(rdata));
    vram_model u_vram_model (
        .clk_sys_i(clk_sys_i), .req_i(req), .we_i(we), .addr_i(addr),
        .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (busy && fetch)
            both_hi <= both_hi + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            summarize();
        end
    end
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_mem(input logic [18:0] a, input logic [7:0] e);
        chk({11'h000, u_vram_model.mem[a]}, {11'h000, e});
    endtask
    task automatic ctl(input logic [2:0] la, input logic [7:0] b,
                       input logic st, input logic sb, input logic iw);
        @(negedge clk_sys_i);
        la_wr = la;
        la_byte = b;
        st_wr = st;
        st_bit = sb;
        irq_wr = iw;
        @(negedge clk_sys_i);
        la_wr = 3'h0;
        st_wr = 1'b0;
        irq_wr = 1'b0;
    endtask
    // junk above bit 18 must be dropped
    task automatic set_list(input logic [18:0] a);
        ctl(3'h1, a[7:0], 1'b0, 1'b0, 1'b0);
        ctl(3'h2, a[15:8], 1'b0, 1'b0, 1'b0);
        ctl(3'h4, {5'h1F, a[18:16]}, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic run();
        ctl(3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
        chk(fetch, 1'b1);
        while (busy || fetch)
            @(negedge clk_sys_i);
    endtask
    // unused upper bits of each field are set to catch sloppy decoding
    task automatic cb(input logic [18:0] a, s, input logic [11:0] ss,
                      input logic [18:0] d, input logic [11:0] ds,
                      input logic [8:0] w, input logic [7:0] h, am, xm,
                      input logic [7:0] cm, zm, pt, ct);
        logic [151:0] v;
        v = {ct, pt, zm, cm, xm, am, h, 7'h7F, w, 4'hF, ds, 5'h1F, d,
             4'hF, ss, 5'h1F, s};
        for (int i = 0; i < 19; i++)
            u_vram_model.mem[a + 19'(i)] = v[8*i +: 8];
    endtask
    function automatic logic [7:0] mix(input int m, input logic [7:0] d);
        case (m)
            1: mix = 8'h30;
            2: mix = d + 8'h30;
            3: mix = d | 8'h30;
            4: mix = d & 8'h30;
            5: mix = d ^ 8'h30;
            default: mix = {4'h3, d[3:0]};
        endcase
    endfunction
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        chk(busy, 1'b0);
        chk(fetch, 1'b0);
        chk(irq, 1'b0);
        chk(list_ptr, 19'h00000);
        $display("test reset done");
        for (int i = 0; i < 512; i++)
            u_vram_model.mem[19'h00F00 + 19'(i)] = 8'(i);
        for (int i = 0; i < 1024; i++)
            u_vram_model.mem[19'h02000 + 19'(i)] = 8'hEE;
        // list starts near the top so the first block wraps
        cb(19'h7FFF8, 19'h01080, 12'd16, 19'h02040, 12'd32, 9'd5, 8'd1,
           8'h0F, 8'h30, 8'hFF, 8'h00, 8'h81, 8'hB8);
        cb(19'h0000B, 19'h03000, 12'd0, 19'h0210E, 12'd16, 9'd1, 8'd0,
           8'h77, 8'h77, 8'h00, 8'h19, 8'h00, 8'h48);
        for (int m = 1; m < 7; m++)
        begin
            u_vram_model.mem[19'h01100 + 19'(m)] = 8'h30;
            u_vram_model.mem[19'h02200 + 19'(m)] = 8'h20 + 8'(m);
            cb(19'h0000B + 19'(19 * m), 19'h01100 + 19'(m), 12'd0,
               19'h02200 + 19'(m), 12'd0, 9'd0, 8'd0, 8'hFF, 8'h00,
               8'hF1, 8'h00, 8'h00, {4'(m != 6) << 3} | 8'(m));
        end
        irq_en = 1'b1;
        ctl(3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
        set_list(19'h7FFF8);
        chk(list_ptr, 19'h7FFF8);
        run();
        chk(irq, 1'b1);
        chk(both_hi, 0);
        chk(list_ptr, 19'h7FFF8);
        chk(coll, 19'h00025);
        for (int y = 0; y < 2; y++)
            for (int x = 0; x < 6; x++)
                chk_mem(19'h02040 - 19'(32 * y) + 19'(x),
                    ((8'h80 - 8'(16 * y + x % 2)) & 8'h0F) ^ 8'h30);
        chk_mem(19'h02046, 8'hEE);
        for (int k = 0; k < 4; k++)
        begin
            chk_mem(19'h0210E - 19'(2 * k), 8'h77);
            chk_mem(19'h0211E - 19'(2 * k), 8'h77);
        end
        chk_mem(19'h0210D, 8'hEE);
        for (int m = 1; m < 7; m++)
            chk_mem(19'h02200 + 19'(m), mix(m, 8'h20 + 8'(m)));
        $display("test chain done");
        irq_en = 1'b0;
        ctl(3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
        chk(irq, 1'b0);
        set_list(19'h0000B + 19'd114);
        run();
        chk(irq, 1'b0);
        chk(coll, 19'h00035);
        chk_mem(19'h02206, 8'h36);
        $display("test nibble done");
        // mode 1 with zero collision mask takes the fast path
        cb(19'h05000, 19'h01101, 12'd0, 19'h02300, 12'd0, 9'd0, 8'd0,
           8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
        u_vram_model.mem[19'h02300] = 8'h26;
        set_list(19'h05000);
        run();
        chk(coll, 19'h00035);
        chk_mem(19'h02300, 8'h30);
        $display("test fast overwrite done");
        irq_en = 1'b1;
        ctl(3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
        cb(19'h04000, 19'h10000, 12'd0, 19'h20000, 12'd0, 9'd511, 8'd255,
           8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        set_list(19'h04000);
        ctl(3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
        repeat (60) @(negedge clk_sys_i);
        chk(busy, 1'b1);
        // a frozen engine must ignore the abort strobe
        ce = 1'b0;
        ctl(3'h0, 8'h00, 1'b1, 1'b0, 1'b0);
        chk(busy, 1'b1);
        ce = 1'b1;
        ctl(3'h0, 8'h00, 1'b1, 1'b0, 1'b0);
        chk(busy, 1'b0);
        chk(fetch, 1'b0);
        chk(irq, 1'b0);
        $display("test abort done");
        summarize();
    end
endmodule // tb
